// >>> hw/wake_filter_pkg.sv
package wake_filter_pkg;
    localparam int NUM_FILTERS = 32;
    localparam int MASK_BITS   = 128;
    localparam int MASK_WORDS  = 4;
    localparam int NUM_ENTRIES = 33;
    localparam int ADR_W       = 12;
    localparam int CNT_W       = 10;

    localparam logic [11:0] CFG_BASE   = 12'h150;
    localparam logic [11:0] CFG_LAST   = 12'h1cc;
    localparam logic [11:0] MASK_BASE  = 12'h200;
    localparam logic [11:0] MASK_LAST  = 12'h3fc;
    localparam logic [11:0] ENTRY_BASE = 12'h400;
    localparam logic [11:0] ENTRY_LAST = 12'h504;
    localparam logic [11:0] STATUS_OFS = 12'h100;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h104;
    localparam logic [11:0] CONTROL_OFS  = 12'h108;

    localparam int CFG_ENABLE_BIT = 31;
    localparam int CFG_TYPE_HI    = 25;
    localparam int CFG_TYPE_LO    = 24;
    localparam int CFG_OFS_HI     = 23;
    localparam int CFG_OFS_LO     = 16;
    localparam int CFG_CRC_HI     = 15;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h83ff_ffff;

    localparam int ENTRY_VALID_BIT = 31;
    localparam int ENTRY_SRC_BIT   = 30;
    localparam logic [31:0] ENTRY_HI_MASK = 32'hc000_ffff;

    localparam int STS_INDEX_HI   = 4;
    localparam int STS_WAKE_BIT   = 8;
    localparam int STS_ADDR_BIT   = 9;
    localparam logic [31:0] STS_EVENT_MASK = 32'h0000_0300;
    localparam int CTL_WAKE_EN_BIT = 0;

    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    localparam logic [CNT_W-1:0] DA_FIRST = 10'h000;
    localparam logic [CNT_W-1:0] SA_FIRST = 10'h006;
    localparam logic [CNT_W-1:0] ADDR_END = 10'h00c;
    localparam int MC_BIT = 40;
endpackage

// >>> hw/wake_filter.sv
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Operation
// R1: Thirty-two filters, each spanning up to 128 bytes.
// R2: Filter acts only when config bit 31 set.
// R3: Bits 25:24 choose unicast, multicast or all.
// R4: Bits 23:16 give start byte from destination.
// R5: Computed CRC-16 equal to bits 15:0 matches.
// R6: Mask bit j includes frame byte offset+j.
// R7: Mask reached as four words, low first.
// R8: USB or lite reset restores filter 0 image.
// R9: Filter 0 image from EEPROM, else OTP, else zero.
// R10: Config at 150h-1CCh, masks at 200h-3FCh.
// R11: Address entry used only while valid bit set.
// R12: Entry bit 30 selects source, else destination.
// R13: Address 47:32 in word0, 31:0 in word1.
// R14: Software clears valid before rewriting an entry.
// R15: Address entries at 400h-504h, two words each.
// R16: Matching filter index recorded in bits 4:0.
// R17: Wakeup-frame flag at bit 8 sticks until cleared.
// R18: CRC-16 all-ones seed, filters evaluated in parallel.
// R19: Any valid entry equal to selected field matches.
module wake_filter
    import wake_filter_pkg::*;
(
    input  wire logic                        CLK,
    input  wire logic                        RESET_N,
    input  wire logic                        WB_CYC_I,
    input  wire logic                        WB_STB_I,
    input  wire logic                        WB_WE_I,
    input  wire logic [wake_filter_pkg::ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]                  WB_SEL_I,
    input  wire logic [31:0]                 WB_DAT_I,
    output logic      [31:0]                 WB_DAT_O,
    output logic                             WB_ACK_O,
    input  wire logic                        RX_VALID,
    input  wire logic [7:0]                  RX_DATA,
    input  wire logic                        RX_SOF,
    input  wire logic                        RX_EOF,
    input  wire logic                        RX_ERR,
    input  wire logic                        USB_RESET,
    input  wire logic                        LITE_RESET,
    input  wire logic                        IMAGE_LOAD,
    input  wire logic                        EE_VALID,
    input  wire logic [31:0]                 EE_CFG,
    input  wire logic [127:0]                EE_MASK,
    input  wire logic                        OTP_VALID,
    input  wire logic [31:0]                 OTP_CFG,
    input  wire logic [127:0]                OTP_MASK,
    output logic                             WAKEUP,
    output logic                             ADDR_MATCH,
    output logic                             IRQ
);
    import wake_filter_pkg::*;

    logic [31:0]      cfg_reg [NUM_FILTERS];
    logic [31:0]      mask_reg [NUM_FILTERS*MASK_WORDS];
    logic [31:0]      entry_hi_reg [NUM_ENTRIES];
    logic [31:0]      entry_lo_reg [NUM_ENTRIES];
    logic [15:0]      crc_reg [NUM_FILTERS];
    logic [31:0]      img_cfg_reg;
    logic [127:0]     img_mask_reg;
    logic [31:0]      status_reg;
    logic [31:0]      irq_mask_reg;
    logic [31:0]      control_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [47:0]      da_reg;
    logic [47:0]      sa_reg;
    logic             in_frame_reg;
    logic             soft_reset;
    logic             wb_req;
    logic             wb_wr;
    logic [CNT_W-1:0] byte_idx;
    logic [47:0]      da_next;
    logic [47:0]      sa_next;
    logic             frame_end;
    logic [NUM_FILTERS-1:0] filter_hit;
    logic [NUM_ENTRIES-1:0] entry_hit;
    logic             wake_event;
    logic             addr_event;
    logic [31:0]      rd_data;
    logic [31:0]      img_cfg_next;
    logic [127:0]     img_mask_next;

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic in_range(input logic [11:0] a,
                                      input logic [11:0] lo,
                                      input logic [11:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // One CRC-16 step per byte, data bits taken least significant first.
    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                               input logic [7:0]  d);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[15] ^ d[i];
            r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    function automatic logic [4:0] first_hit(input logic [NUM_FILTERS-1:0] h);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
            if (h[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    assign soft_reset = USB_RESET | LITE_RESET;
    assign wb_req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wb_wr      = wb_req & WB_WE_I;
    assign byte_idx   = RX_SOF ? DA_FIRST : cnt_reg;
    assign frame_end  = RX_EOF & in_frame_reg & ~RX_ERR;
    assign da_next    = {da_reg[39:0], RX_DATA};
    assign sa_next    = {sa_reg[39:0], RX_DATA};

    always_comb begin
        if (EE_VALID) begin //R9
            img_cfg_next  = EE_CFG & CFG_WRITE_MASK;
            img_mask_next = EE_MASK;
        end else if (OTP_VALID) begin
            img_cfg_next  = OTP_CFG & CFG_WRITE_MASK;
            img_mask_next = OTP_MASK;
        end else begin
            img_cfg_next  = 32'h0000_0000;
            img_mask_next = '0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            img_cfg_reg  <= 32'h0000_0000;
            img_mask_reg <= '0;
        end else if (IMAGE_LOAD) begin
            img_cfg_reg  <= img_cfg_next; //R9
            img_mask_reg <= img_mask_next;
        end
    end

    // Filter configuration words; filter 0 falls back to its image on soft resets.
    always_ff @(posedge CLK) begin
        for (int f = 0; f < NUM_FILTERS; f++) begin
            if (!RESET_N) begin
                cfg_reg[f] <= 32'h0000_0000;
            end else if (f == 0 && IMAGE_LOAD) begin
                cfg_reg[f] <= img_cfg_next; //R9
            end else if (soft_reset) begin
                cfg_reg[f] <= (f == 0) ? img_cfg_reg : 32'h0000_0000; //R8
            end else if (wb_wr && WB_ADR_I == CFG_BASE + 12'(f * 4)) begin //R10
                cfg_reg[f] <= lane_merge(cfg_reg[f], WB_DAT_I, WB_SEL_I) & CFG_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge CLK) begin
        for (int w = 0; w < NUM_FILTERS * MASK_WORDS; w++) begin
            if (!RESET_N) begin
                mask_reg[w] <= 32'h0000_0000;
            end else if (w < MASK_WORDS && IMAGE_LOAD) begin
                mask_reg[w] <= img_mask_next[(w % MASK_WORDS)*32 +: 32]; //R9
            end else if (soft_reset) begin
                mask_reg[w] <= (w < MASK_WORDS) ? img_mask_reg[(w % MASK_WORDS)*32 +: 32]
                                                : 32'h0000_0000; //R8
            end else if (wb_wr && WB_ADR_I == MASK_BASE + 12'(w * 4)) begin //R7
                mask_reg[w] <= lane_merge(mask_reg[w], WB_DAT_I, WB_SEL_I);
            end
        end
    end

    // Entries are compared straight from storage, so software clears valid first.
    always_ff @(posedge CLK) begin
        for (int e = 0; e < NUM_ENTRIES; e++) begin
            if (!RESET_N || soft_reset) begin
                entry_hi_reg[e] <= 32'h0000_0000;
                entry_lo_reg[e] <= 32'h0000_0000;
            end else if (wb_wr && WB_ADR_I == ENTRY_BASE + 12'(e * 8)) begin //R15
                entry_hi_reg[e] <= lane_merge(entry_hi_reg[e], WB_DAT_I, WB_SEL_I)
                                   & ENTRY_HI_MASK; //R13
            end else if (wb_wr && WB_ADR_I == ENTRY_BASE + 12'(e * 8 + 4)) begin
                entry_lo_reg[e] <= lane_merge(entry_lo_reg[e], WB_DAT_I, WB_SEL_I); //R14
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N || soft_reset) begin
            irq_mask_reg <= 32'h0000_0000;
            control_reg  <= 32'h0000_0000;
        end else if (wb_wr && WB_ADR_I == IRQ_MASK_OFS) begin
            irq_mask_reg <= lane_merge(irq_mask_reg, WB_DAT_I, WB_SEL_I) & STS_EVENT_MASK;
        end else if (wb_wr && WB_ADR_I == CONTROL_OFS) begin
            control_reg <= lane_merge(control_reg, WB_DAT_I, WB_SEL_I) & 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cnt_reg      <= DA_FIRST;
            in_frame_reg <= 1'b0;
            da_reg       <= 48'h0000_0000_0000;
            sa_reg       <= 48'h0000_0000_0000;
        end else begin
            if (RX_VALID && RX_SOF) begin
                in_frame_reg <= 1'b1;
            end else if (RX_EOF) begin
                in_frame_reg <= 1'b0;
            end
            if (RX_VALID && (RX_SOF || in_frame_reg)) begin
                if (byte_idx != {CNT_W{1'b1}}) begin
                    cnt_reg <= byte_idx + 10'h001;
                end
                if (byte_idx < SA_FIRST) begin
                    da_reg <= da_next;
                end else if (byte_idx < ADDR_END) begin
                    sa_reg <= sa_next;
                end
            end
        end
    end

    generate
        for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filter
            logic [CNT_W-1:0] rel;
            logic             take;
            logic [1:0]       atype;
            logic             type_ok;
            assign rel   = byte_idx - {2'b00, cfg_reg[f][CFG_OFS_HI:CFG_OFS_LO]}; //R4
            assign take  = (byte_idx >= {2'b00, cfg_reg[f][CFG_OFS_HI:CFG_OFS_LO]})
                         && (rel < CNT_W'(MASK_BITS))
                         && mask_reg[f*MASK_WORDS + int'(rel[6:5])][rel[4:0]]; //R6
            assign atype = cfg_reg[f][CFG_TYPE_HI:CFG_TYPE_LO];
            assign type_ok = atype[0] || (atype[1] == da_reg[MC_BIT]); //R3
            assign filter_hit[f] = frame_end && cfg_reg[f][CFG_ENABLE_BIT] && type_ok
                                 && (crc_reg[f] == cfg_reg[f][CFG_CRC_HI:0]); //R2 R5

            always_ff @(posedge CLK) begin
                if (!RESET_N) begin
                    crc_reg[f] <= CRC_SEED;
                end else if (RX_VALID && (RX_SOF || in_frame_reg)) begin
                    if (take) begin //R18 R1
                        crc_reg[f] <= crc16_byte(RX_SOF ? CRC_SEED : crc_reg[f], RX_DATA);
                    end else if (RX_SOF) begin
                        crc_reg[f] <= CRC_SEED;
                    end
                end
            end
        end

        for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_entry
            logic [47:0] stored;
            assign stored = {entry_hi_reg[e][15:0], entry_lo_reg[e]}; //R13
            assign entry_hit[e] = frame_end && entry_hi_reg[e][ENTRY_VALID_BIT] //R11
                                && (stored == (entry_hi_reg[e][ENTRY_SRC_BIT] ? sa_reg
                                                                             : da_reg)); //R12
        end
    endgenerate

    assign wake_event = (|filter_hit) && control_reg[CTL_WAKE_EN_BIT];
    assign addr_event = |entry_hit; //R19

    // Status: a hardware set in the same cycle as a one-to-clear wins.
    always_ff @(posedge CLK) begin
        if (!RESET_N || soft_reset) begin
            status_reg <= 32'h0000_0000;
        end else begin
            if (wake_event) begin
                status_reg[STS_WAKE_BIT] <= 1'b1; //R17
                status_reg[STS_INDEX_HI:0] <= first_hit(filter_hit); //R16
            end else if (wb_wr && WB_ADR_I == STATUS_OFS && WB_SEL_I[1]
                         && WB_DAT_I[STS_WAKE_BIT]) begin
                status_reg[STS_WAKE_BIT] <= 1'b0;
                status_reg[STS_INDEX_HI:0] <= 5'h00;
            end
            if (addr_event) begin
                status_reg[STS_ADDR_BIT] <= 1'b1;
            end else if (wb_wr && WB_ADR_I == STATUS_OFS && WB_SEL_I[1]
                         && WB_DAT_I[STS_ADDR_BIT]) begin
                status_reg[STS_ADDR_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            WAKEUP     <= 1'b0;
            ADDR_MATCH <= 1'b0;
            IRQ        <= 1'b0;
        end else begin
            WAKEUP     <= wake_event;
            ADDR_MATCH <= addr_event;
            IRQ        <= |(status_reg & irq_mask_reg);
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (in_range(WB_ADR_I, CFG_BASE, CFG_LAST) && WB_ADR_I[1:0] == 2'b00) begin
            // The config block does not start on a 32-word boundary, so the word index wraps.
            rd_data = cfg_reg[5'(WB_ADR_I[6:2] - CFG_BASE[6:2])];
        end else if (in_range(WB_ADR_I, MASK_BASE, MASK_LAST)) begin
            rd_data = mask_reg[WB_ADR_I[8:2]];
        end else if (in_range(WB_ADR_I, ENTRY_BASE, ENTRY_LAST)) begin
            rd_data = WB_ADR_I[2] ? entry_lo_reg[int'(WB_ADR_I[8:3])]
                                  : entry_hi_reg[int'(WB_ADR_I[8:3])];
        end else if (WB_ADR_I == STATUS_OFS) begin
            rd_data = status_reg;
        end else if (WB_ADR_I == IRQ_MASK_OFS) begin
            rd_data = irq_mask_reg;
        end else if (WB_ADR_I == CONTROL_OFS) begin
            rd_data = control_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= (wb_req && !WB_WE_I) ? rd_data : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for more than one cycle");
    ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acknowledged on next edge");
    cfg_write_a: assert property (wb_wr && WB_ADR_I == CFG_BASE + 12'h014 && WB_SEL_I == 4'hf
                                  && !soft_reset
                                  |=> cfg_reg[5] == ($past(WB_DAT_I) & CFG_WRITE_MASK)) //R10
        else $error("config word of filter 5 not written");
    disabled_quiet_a: assert property (!cfg_reg[0][CFG_ENABLE_BIT] |-> !filter_hit[0]) //R2
        else $error("disabled filter produced a hit");
    wake_flag_a: assert property (wake_event |=> status_reg[STS_WAKE_BIT] && WAKEUP) //R17
        else $error("wakeup flag not set after match");
    flag_sticky_a: assert property (status_reg[STS_WAKE_BIT] && !soft_reset
                                    && !(wb_wr && WB_ADR_I == STATUS_OFS)
                                    |=> status_reg[STS_WAKE_BIT]) //R17
        else $error("wakeup flag dropped without a clear");
    index_record_a: assert property (wake_event && filter_hit[5] && !(|filter_hit[4:0])
                                     && !soft_reset
                                     |=> status_reg[STS_INDEX_HI:0] == 5'h05) //R16
        else $error("matching filter index not recorded");
    restore_image_a: assert property (soft_reset && !IMAGE_LOAD
                                      |=> cfg_reg[0] == $past(img_cfg_reg)
                                          && mask_reg[0] == $past(img_mask_reg[31:0])) //R8
        else $error("filter 0 not restored from image");
    image_pick_a: assert property (IMAGE_LOAD && EE_VALID
                                   |=> img_cfg_reg == ($past(EE_CFG) & CFG_WRITE_MASK)) //R9
        else $error("image not taken from EEPROM source");
    entry_valid_a: assert property (!entry_hi_reg[0][ENTRY_VALID_BIT] |-> !entry_hit[0]) //R11
        else $error("invalid entry matched");
    irq_level_a: assert property (|(status_reg & irq_mask_reg) |=> IRQ)
        else $error("interrupt not raised for unmasked status");

    wake_seen_c: cover property (wake_event);
    addr_seen_c: cover property (addr_event ##1 ADDR_MATCH);
    clear_race_c: cover property (wake_event && wb_wr && WB_ADR_I == STATUS_OFS);
    soft_reset_c: cover property (soft_reset);
endmodule

// >>> verif/mac_rx_model.sv
`timescale 1ns/1ps
module mac_rx_model (
    input  wire logic       CLK,
    output logic            RX_VALID,
    output logic [7:0]      RX_DATA,
    output logic            RX_SOF,
    output logic            RX_EOF,
    output logic            RX_ERR
);
    initial begin
        RX_VALID = 1'b0;
        RX_DATA  = 8'h00;
        RX_SOF   = 1'b0;
        RX_EOF   = 1'b0;
        RX_ERR   = 1'b0;
    end

    // Sends a fourteen byte frame, first byte first, then a one-cycle end marker.
    task automatic send(input logic [111:0] fr, input logic err);
        for (int i = 0; i < 14; i++) begin
            @(posedge CLK);
            RX_VALID <= 1'b1;
            RX_SOF   <= (i == 0);
            RX_DATA  <= fr[111-8*i -: 8];
        end
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_SOF   <= 1'b0;
        RX_EOF   <= 1'b1;
        RX_ERR   <= err;
        // Idle data shows the inverse of the last byte so stale data is never taken as valid.
        RX_DATA  <= ~fr[7:0];
        @(posedge CLK);
        RX_EOF   <= 1'b0;
        RX_ERR   <= 1'b0;
    endtask
endmodule

// >>> verif/wake_filter_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module wake_filter_test import wake_filter_pkg::*;;
    localparam logic [111:0] F1 = 112'h01005e0000fb_021122334455_0800;
    localparam logic [31:0]  EE_C = 32'h8012abcd;
    localparam logic [31:0]  OTP_C = 32'h01234567;
    localparam logic [127:0] EE_M = 128'h12345678_00000000_00000000_9abcdef0;
    localparam logic [127:0] OTP_M = 128'h0f0f0f0f_00000000_00000000_f0f0f0f0;
    logic CLK, RESET_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, RX_VALID, RX_SOF, RX_EOF;
    logic RX_ERR, USB_RESET, LITE_RESET, IMAGE_LOAD, EE_VALID, OTP_VALID, WAKEUP;
    logic ADDR_MATCH, IRQ;
    logic [ADR_W-1:0] WB_ADR_I;
    logic [3:0]       WB_SEL_I;
    logic [31:0]      WB_DAT_I, WB_DAT_O, EE_CFG, OTP_CFG;
    logic [127:0]     EE_MASK, OTP_MASK;
    logic [7:0]       RX_DATA;
    int checks = 0;
    int n_fail = 0;
    int n_wake = 0;
    int n_addr = 0;

    wake_filter uut (.CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
        .RX_SOF(RX_SOF), .RX_EOF(RX_EOF), .RX_ERR(RX_ERR), .USB_RESET(USB_RESET),
        .LITE_RESET(LITE_RESET), .IMAGE_LOAD(IMAGE_LOAD), .EE_VALID(EE_VALID),
        .EE_CFG(EE_CFG), .EE_MASK(EE_MASK), .OTP_VALID(OTP_VALID), .OTP_CFG(OTP_CFG),
        .OTP_MASK(OTP_MASK), .WAKEUP(WAKEUP), .ADDR_MATCH(ADDR_MATCH), .IRQ(IRQ));
    mac_rx_model mac (.CLK(CLK), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_SOF(RX_SOF),
        .RX_EOF(RX_EOF), .RX_ERR(RX_ERR));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        if (WAKEUP === 1'b1) n_wake <= n_wake + 1;
        if (ADDR_MATCH === 1'b1) n_addr <= n_addr + 1;
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        int n;
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        WB_SEL_I <= 4'hf;
        for (n = 0; n < 20; n++) begin
            @(posedge CLK);
            if (WB_ACK_O === 1'b1) break;
        end
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I  <= 1'b0;
        if (n == 20) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        wb(1'b1, a, d, rd);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] rd;
        wb(1'b0, a, 32'h0, rd);
        `CHK(rd, e)
    endtask

    // Reference CRC: data bits taken least significant first, register shifts left.
    function automatic logic [15:0] crc16(input logic [111:0] fr, input int ofs,
                                          input logic [127:0] m);
        logic [15:0] c;
        logic [7:0]  d;
        c = CRC_SEED;
        for (int j = 0; j < 128; j++) begin
            if (m[j] && ofs + j < 14) begin
                d = fr[111-8*(ofs+j) -: 8];
                for (int b = 0; b < 8; b++) begin
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? CRC_POLY : 16'h0000);
                end
            end
        end
        return c;
    endfunction

    task automatic test_regs();
        logic [11:0] a [6] = '{12'h15c, 12'h1cc, 12'h3fc, 12'h500, 12'h504, 12'h010};
        logic [31:0] e [6] = '{32'h83ffffff, 32'h83ffffff, 32'hffffffff, 32'hc000ffff,
                               32'hffffffff, 32'h0};
        for (int i = 0; i < 6; i++) begin
            rdchk(a[i], 32'h0);
            wr(a[i], 32'hffffffff);
            rdchk(a[i], e[i]);
            wr(a[i], 32'h0);
        end
        $display("test_regs finished");
    endtask

    task automatic test_wake();
        logic [15:0] crc;
        logic [1:0] ty [6] = '{2'b01, 2'b01, 2'b00, 2'b10, 2'b01, 2'b11};
        logic en [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic er [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        int ex [6] = '{1, 0, 0, 1, 0, 1};
        int w0;
        crc = crc16(F1, 2, 128'h5);
        wr(12'h250, 32'h5);
        wr(CONTROL_OFS, 32'h1);
        wr(IRQ_MASK_OFS, 32'h100);
        for (int i = 0; i < 6; i++) begin
            wr(12'h164, {en[i], 5'h00, ty[i], 8'h02, crc});
            w0 = n_wake;
            mac.send(F1, er[i]);
            repeat (3) @(posedge CLK);
            `CHK(n_wake - w0, ex[i])
            if (ex[i] == 1) begin
                rdchk(STATUS_OFS, 32'h105);
                `CHK(IRQ, 1'b1)
                wr(STATUS_OFS, 32'h100);
                repeat (3) @(posedge CLK);
                rdchk(STATUS_OFS, 32'h0);
                `CHK(IRQ, 1'b0)
            end
        end
        wr(IRQ_MASK_OFS, 32'h0);
        mac.send(F1, 1'b0);
        repeat (3) @(posedge CLK);
        `CHK(IRQ, 1'b0)
        wr(IRQ_MASK_OFS, 32'h100);
        repeat (3) @(posedge CLK);
        `CHK(IRQ, 1'b1)
        wr(STATUS_OFS, 32'h100);
        wr(12'h164, 32'h0);
        $display("test_wake finished");
    endtask

    task automatic test_addr();
        logic [31:0] w1 [4] = '{32'h22334455, 32'h22334455, 32'h5e0000fb, 32'h5e0000fb};
        logic [31:0] w0 [4] = '{32'hc0000211, 32'h40000211, 32'h80000100, 32'hc0000100};
        int ex [4] = '{1, 0, 1, 0};
        int a0;
        for (int i = 0; i < 4; i++) begin
            wr(12'h438, 32'h0);
            wr(12'h43c, w1[i]);
            wr(12'h438, w0[i]);
            a0 = n_addr;
            mac.send(F1, 1'b0);
            repeat (3) @(posedge CLK);
            `CHK(n_addr - a0, ex[i])
            rdchk(STATUS_OFS, (ex[i] == 1) ? 32'h200 : 32'h0);
            wr(STATUS_OFS, 32'h200);
        end
        wr(12'h438, 32'h0);
        $display("test_addr finished");
    endtask

    task automatic test_image();
        logic [31:0]  c;
        logic [127:0] m;
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? EE_C : (k == 1) ? OTP_C : 32'h0;
            m = (k == 0) ? EE_M : (k == 1) ? OTP_M : 128'h0;
            @(posedge CLK);
            EE_VALID   <= (k == 0);
            OTP_VALID  <= (k == 1);
            IMAGE_LOAD <= 1'b1;
            @(posedge CLK);
            IMAGE_LOAD <= 1'b0;
            wr(CFG_BASE, 32'h0);
            wr(MASK_BASE, 32'h0);
            wr(CONTROL_OFS, 32'h1);
            @(posedge CLK);
            USB_RESET  <= (k != 1);
            LITE_RESET <= (k == 1);
            @(posedge CLK);
            USB_RESET  <= 1'b0;
            LITE_RESET <= 1'b0;
            rdchk(CFG_BASE, c);
            rdchk(MASK_BASE, m[31:0]);
            rdchk(12'h20c, m[127:96]);
            rdchk(CONTROL_OFS, 32'h0);
        end
        $display("test_image finished");
    endtask

    initial begin
        RESET_N    = 1'b0;
        WB_CYC_I   = 1'b0;
        WB_STB_I   = 1'b0;
        WB_WE_I    = 1'b0;
        WB_ADR_I   = 12'h000;
        WB_SEL_I   = 4'h0;
        WB_DAT_I   = 32'h0;
        USB_RESET  = 1'b0;
        LITE_RESET = 1'b0;
        IMAGE_LOAD = 1'b0;
        EE_VALID   = 1'b0;
        OTP_VALID  = 1'b0;
        EE_CFG     = EE_C;
        OTP_CFG    = OTP_C;
        EE_MASK    = EE_M;
        OTP_MASK   = OTP_M;
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        test_regs();
        test_wake();
        test_addr();
        test_image();
        report_and_stop();
    end
endmodule
